// *** logic/fc_params.svh ***
`ifndef FC_PARAMS_SVH
`define FC_PARAMS_SVH
// ==========================================
// Register byte offsets
`define FC_OFS_CTRL 8'h00
`define FC_OFS_STATUS 8'h04
`define FC_OFS_VLIMIT 8'h08
`define FC_OFS_SLEW 8'h0c
`define FC_OFS_OPENV 8'h10
`define FC_OFS_SETPT 8'h14
`define FC_OFS_RAMP 8'h18
`define FC_OFS_PGAIN 8'h1c
`define FC_OFS_ITIME 8'h20
`define FC_OFS_OUT 8'h24
`define FC_OFS_ISTAT 8'h28
`define FC_OFS_IMASK 8'h2c
// ==========================================
// Field positions
`define FC_CTRL_EN 0
`define FC_CTRL_CLOSED 1
`define FC_CTRL_INTEG 2
`define FC_EV_LIMIT 0
`define FC_EV_RAMPDONE 1
`define FC_EV_UPDATE 2
// ==========================================
// Reset values and scaling
`define FC_FULL_SCALE_UV 25'h0989680
`define FC_RST_VLIMIT 32'h00989680
`define FC_RST_SLEW 32'h00002710
`define FC_RST_PGAIN 32'h00000500
`define FC_RST_ITIME 32'h00002710
`define FC_GAIN_FRAC 8
`define FC_DIV_W 40
// ==========================================
// Timing
`define FC_CLK_PS 5000
`define FC_TICK_PS 1000000000
`define FC_MEAS_MS 10
`endif

// *** logic/fc_pkg.sv ***
package fc_pkg;
  typedef enum logic [1:0] {
    PI_IDLE = 2'b00,
    PI_DIV = 2'b01,
    PI_CALC = 2'b10
  } pi_state_t;
  typedef logic signed [24:0] volt_t;
  typedef logic signed [31:0] field_t;
endpackage

// *** logic/fc_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fc_params.svh"
module fc_divider #(
  parameter int W = `FC_DIV_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [W-1:0] num,
  input wire logic [31:0] den,
  output logic busy,
  output logic done,
  output logic [W-1:0] quo
);
  logic [W-1:0] n_reg;
  logic [32:0] r_reg;
  logic [5:0] cnt_reg;
  wire [32:0] r_sh = {r_reg[31:0], n_reg[W-1]};
  wire fits = r_sh >= {1'b0, den};

  // One quotient bit per clock; the loop period leaves ample room
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      n_reg <= '0;
      r_reg <= '0;
      cnt_reg <= '0;
      quo <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        n_reg <= num;
        r_reg <= '0;
        cnt_reg <= 6'(W);
      end else if (busy) begin
        r_reg <= fits ? r_sh - {1'b0, den} : r_sh;
        n_reg <= n_reg << 1;
        quo <= {quo[W-2:0], fits};
        cnt_reg <= cnt_reg - 6'h01;
        if (cnt_reg == 6'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  a_div_latency: assert property (@(posedge aclk) disable iff (!aresetn)
    start && !busy |-> ##41 done) else $error("divider result late");
endmodule
`default_nettype wire

// *** logic/fc_slew.sv ***
`timescale 1ns/1ps
`default_nettype none
module fc_slew
  import fc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire volt_t target,
  input wire logic [31:0] step,
  output volt_t out_reg
);
  wire signed [33:0] diff = 34'(target) - 34'(out_reg);
  wire signed [33:0] stp = $signed({2'b00, step});
  wire signed [33:0] nstp = -stp;
  volt_t out_next;
  assign out_next = (diff > stp) ? out_reg + 25'(stp) :
                    (diff < nstp) ? out_reg - 25'(stp) : target;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_reg <= '0;
    end else if (tick) begin
      out_reg <= out_next;
    end
  end

  a_slew_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> (34'(out_reg) - 34'($past(out_reg)) <= $past(stp)) &&
    (34'(out_reg) - 34'($past(out_reg)) >= -$past(stp)))
    else $error("output moved faster than slew limit");
endmodule
`default_nettype wire

// *** logic/fc_field_ctrl.sv ***
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fc_params.svh"
module fc_field_ctrl
  import fc_pkg::*;
#(
  parameter int TICK_CYC = `FC_TICK_PS / `FC_CLK_PS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic option_present,
  input wire logic dc_mode,
  input wire logic single_axis,
  input wire logic meas_valid,
  input wire field_t meas_field,
  output volt_t ctrl_out,
  output logic limit_warn,
  output logic irq
);
  // ==========================================
  // Qualifying pins and timebase
  logic [2:0] pins_s1_reg;
  logic [2:0] pins_s2_reg;
  logic [17:0] tick_cnt_reg;
  wire allowed = &pins_s2_reg;
  wire tick = tick_cnt_reg == 18'(TICK_CYC - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_s1_reg <= '0;
      pins_s2_reg <= '0;
      tick_cnt_reg <= '0;
    end else begin
      pins_s1_reg <= {option_present, dc_mode, single_axis};
      pins_s2_reg <= pins_s1_reg;
      tick_cnt_reg <= tick ? 18'h00000 : tick_cnt_reg + 18'h00001;
    end
  end

  // ==========================================
  // Registers
  logic [31:0] ctrl_reg, vlimit_reg, slew_reg, openv_reg, setpt_reg;
  logic [31:0] ramp_reg, pgain_reg, itime_reg;
  logic [2:0] istat_reg, imask_reg;
  wire enable = ctrl_reg[`FC_CTRL_EN];
  wire closed = ctrl_reg[`FC_CTRL_CLOSED];
  wire active = enable && allowed;
  wire integ_on = ctrl_reg[`FC_CTRL_INTEG] && (itime_reg != 32'h0);

  // ==========================================
  // Voltage limit and target selection
  wire [24:0] vlim = (vlimit_reg > 32'(`FC_FULL_SCALE_UV)) ?
                     `FC_FULL_SCALE_UV : vlimit_reg[24:0];
  wire signed [56:0] vlim_p = $signed({32'h0, vlim});
  wire signed [56:0] vlim_n = -vlim_p;

  function automatic volt_t clamp_v(input logic signed [56:0] v,
                                    input logic signed [56:0] hi,
                                    input logic signed [56:0] lo);
    clamp_v = (v > hi) ? 25'(hi) : (v < lo) ? 25'(lo) : 25'(v);
  endfunction

  wire signed [56:0] openv_x = 57'($signed(openv_reg));
  wire open_clamped = (openv_x > vlim_p) || (openv_x < vlim_n);
  volt_t open_target, pi_target_reg, target;
  logic sat_hi_reg, sat_lo_reg;
  // Clamped again here so a changed limit bites before the next pass
  wire signed [56:0] pi_x = 57'(pi_target_reg);
  wire pi_clamped = (pi_x > vlim_p) || (pi_x < vlim_n) ||
                    (sat_hi_reg && pi_x == vlim_p) || (sat_lo_reg && pi_x == vlim_n);
  assign open_target = clamp_v(openv_x, vlim_p, vlim_n);
  assign target = !active ? 25'sh0000000 :
                  closed ? clamp_v(pi_x, vlim_p, vlim_n) : open_target;
  wire target_clamped = active && (closed ? pi_clamped : open_clamped);

  fc_slew u_slew (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .target(target),
    .step(slew_reg),
    .out_reg(ctrl_out)
  );

  assign limit_warn = target_clamped && (ctrl_out == target);

  // ==========================================
  // Setpoint ramp
  field_t sp_cur_reg;
  wire signed [32:0] sp_diff = 33'($signed(setpt_reg)) - 33'(sp_cur_reg);
  wire signed [32:0] rstep = $signed({1'b0, ramp_reg});
  wire ramping = sp_cur_reg != $signed(setpt_reg);
  wire run_pi = active && closed;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_cur_reg <= '0;
    end else if (!run_pi || ramp_reg == 32'h0) begin
      sp_cur_reg <= $signed(setpt_reg);
    end else if (tick) begin
      sp_cur_reg <= (sp_diff > rstep) ? sp_cur_reg + 32'(rstep) :
                    (sp_diff < -rstep) ? sp_cur_reg - 32'(rstep) : $signed(setpt_reg);
    end
  end

  // ==========================================
  // PI loop, one pass per measurement step
  pi_state_t state_reg;
  logic signed [32:0] err_reg;
  logic signed [39:0] acc_reg;
  logic div_done;
  logic [39:0] div_quo;
  wire start_pi = run_pi && meas_valid && state_reg == PI_IDLE;
  wire signed [32:0] err_now = 33'(sp_cur_reg) - 33'(meas_field);
  wire hold_acc = (sat_hi_reg && err_now > 0) || (sat_lo_reg && err_now < 0);
  // Accumulating error per 10 ms step; I counts 10 ms units, so sum/I is the integral over I times 10 ms
  wire signed [39:0] acc_next = !integ_on ? 40'sh0 :
                                hold_acc ? acc_reg : acc_reg + 40'(err_now);
  wire [39:0] acc_mag = acc_next[39] ? 40'(-acc_next) : 40'(acc_next);
  wire signed [40:0] iterm = !integ_on ? 41'sh0 :
                             acc_reg[39] ? -$signed({1'b0, div_quo}) : $signed({1'b0, div_quo});
  wire signed [40:0] psum = 41'(err_reg) + iterm;
  wire signed [57:0] prod = psum * $signed({1'b0, pgain_reg[15:0]});
  wire signed [56:0] scaled = 57'(prod >>> `FC_GAIN_FRAC);

  fc_divider u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_pi && integ_on),
    .num(acc_mag),
    .den(itime_reg),
    .busy(),
    .done(div_done),
    .quo(div_quo)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn || !run_pi) begin
      state_reg <= PI_IDLE;
      err_reg <= '0;
      acc_reg <= '0;
      pi_target_reg <= '0;
      sat_hi_reg <= 1'b0;
      sat_lo_reg <= 1'b0;
    end else begin
      case (state_reg)
        PI_IDLE: begin
          if (start_pi) begin
            err_reg <= err_now;
            acc_reg <= acc_next;
            state_reg <= integ_on ? PI_DIV : PI_CALC;
          end
        end
        PI_DIV: begin
          if (div_done) begin
            state_reg <= PI_CALC;
          end
        end
        PI_CALC: begin
          pi_target_reg <= clamp_v(scaled, vlim_p, vlim_n);
          sat_hi_reg <= scaled > vlim_p;
          sat_lo_reg <= scaled < vlim_n;
          state_reg <= PI_IDLE;
        end
        default: begin
          state_reg <= PI_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Events and interrupt
  logic warn_d_reg, ramp_d_reg;
  wire [2:0] events = {state_reg == PI_CALC, ramp_d_reg && !ramping, limit_warn && !warn_d_reg};
  assign irq = |(istat_reg & imask_reg);

  // ==========================================
  // AXI4-Lite slave
  logic [7:0] aw_addr_reg;
  logic aw_held_reg, w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  wire do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  wire [31:0] wval = w_data_reg;
  wire we_ctrl = do_write && aw_addr_reg == `FC_OFS_CTRL;
  wire we_vlim = do_write && aw_addr_reg == `FC_OFS_VLIMIT;
  wire we_slew = do_write && aw_addr_reg == `FC_OFS_SLEW;
  wire we_openv = do_write && aw_addr_reg == `FC_OFS_OPENV;
  wire we_setpt = do_write && aw_addr_reg == `FC_OFS_SETPT;
  wire we_ramp = do_write && aw_addr_reg == `FC_OFS_RAMP;
  wire we_pgain = do_write && aw_addr_reg == `FC_OFS_PGAIN;
  wire we_itime = do_write && aw_addr_reg == `FC_OFS_ITIME;
  wire we_istat = do_write && aw_addr_reg == `FC_OFS_ISTAT && w_strb_reg[0];
  wire we_imask = do_write && aw_addr_reg == `FC_OFS_IMASK && w_strb_reg[0];
  wire w_ok = we_ctrl || we_vlim || we_slew || we_openv || we_setpt || we_ramp ||
              we_pgain || we_itime || aw_addr_reg == `FC_OFS_ISTAT ||
              aw_addr_reg == `FC_OFS_IMASK || aw_addr_reg == `FC_OFS_STATUS ||
              aw_addr_reg == `FC_OFS_OUT;
  // Set wins over a simultaneous write-one clear
  wire [2:0] istat_next = (istat_reg & ~(we_istat ? wval[2:0] : 3'h0)) | events;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= '0;
      vlimit_reg <= `FC_RST_VLIMIT;
      slew_reg <= `FC_RST_SLEW;
      openv_reg <= '0;
      setpt_reg <= '0;
      ramp_reg <= '0;
      pgain_reg <= `FC_RST_PGAIN;
      itime_reg <= `FC_RST_ITIME;
      istat_reg <= '0;
      imask_reg <= '0;
      warn_d_reg <= 1'b0;
      ramp_d_reg <= 1'b0;
    end else begin
      ctrl_reg <= we_ctrl ? merge(ctrl_reg, wval, w_strb_reg) & 32'h00000007 : ctrl_reg;
      vlimit_reg <= we_vlim ? merge(vlimit_reg, wval, w_strb_reg) : vlimit_reg;
      slew_reg <= we_slew ? merge(slew_reg, wval, w_strb_reg) : slew_reg;
      openv_reg <= we_openv ? merge(openv_reg, wval, w_strb_reg) : openv_reg;
      setpt_reg <= we_setpt ? merge(setpt_reg, wval, w_strb_reg) : setpt_reg;
      ramp_reg <= we_ramp ? merge(ramp_reg, wval, w_strb_reg) : ramp_reg;
      pgain_reg <= we_pgain ? merge(pgain_reg, wval, w_strb_reg) & 32'h0000ffff : pgain_reg;
      itime_reg <= we_itime ? merge(itime_reg, wval, w_strb_reg) : itime_reg;
      istat_reg <= istat_next;
      imask_reg <= we_imask ? wval[2:0] : imask_reg;
      warn_d_reg <= limit_warn;
      ramp_d_reg <= ramping;
    end
  end

  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire [31:0] status = {28'h0, active, ramping, limit_warn, allowed};
  wire r_ok = ra <= `FC_OFS_IMASK;
  wire [31:0] rd_data =
    ra == `FC_OFS_CTRL ? ctrl_reg : ra == `FC_OFS_STATUS ? status :
    ra == `FC_OFS_VLIMIT ? vlimit_reg : ra == `FC_OFS_SLEW ? slew_reg :
    ra == `FC_OFS_OPENV ? openv_reg : ra == `FC_OFS_SETPT ? setpt_reg :
    ra == `FC_OFS_RAMP ? ramp_reg : ra == `FC_OFS_PGAIN ? pgain_reg :
    ra == `FC_OFS_ITIME ? itime_reg : ra == `FC_OFS_OUT ? 32'(ctrl_out) :
    ra == `FC_OFS_ISTAT ? {29'h0, istat_reg} :
    ra == `FC_OFS_IMASK ? {29'h0, imask_reg} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= r_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_gate_pins: assert property (!allowed |-> target == 25'sh0)
    else $error("target nonzero while control not allowed");
  a_target_limit: assert property (target <= $signed({1'b0, vlim}) && target >= -$signed({1'b0, vlim}))
    else $error("target beyond voltage limit");
  a_disable_zero: assert property (!active && ctrl_out == 25'sh0 |=> ctrl_out == 25'sh0)
    else $error("output left zero while disabled");
  a_open_track: assert property (active && !closed && !open_clamped |-> target == $signed(openv_reg[24:0]))
    else $error("open loop target mismatch");
  a_error_form: assert property (start_pi |=> err_reg == $past(err_now))
    else $error("error not setpoint minus feedback");
  a_prop_zero: assert property (state_reg == PI_CALC && !integ_on && err_reg == 33'sh0
    |=> pi_target_reg == 25'sh0) else $error("proportional output not zero");
  a_ramp_step: assert property (run_pi && ramp_reg == 32'h0 |=> sp_cur_reg == $past($signed(setpt_reg)))
    else $error("zero ramp rate did not step");
  a_warn_at_limit: assert property (limit_warn |-> ctrl_out == 25'(vlim) || ctrl_out == -25'(vlim))
    else $error("warning without output at limit");
  a_no_windup: assert property (start_pi && integ_on && hold_acc |=> acc_reg == $past(acc_reg))
    else $error("integral grew while clamped");
  a_one_update: assert property (start_pi |=> state_reg != PI_IDLE ##1 !start_pi)
    else $error("second update in same pass");

  c_open_warn: cover property (active && !closed ##1 limit_warn);
  c_pi_update: cover property (state_reg == PI_CALC && integ_on);
  c_ramp_done: cover property (events[`FC_EV_RAMPDONE]);
  c_disable_slew: cover property ($fell(active) ##1 ctrl_out != 25'sh0);
endmodule
`default_nettype wire

// *** verif/fc_magnet_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fc_magnet_model
  import fc_pkg::*;
#(
  parameter int MEAS_CYC = 200
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire volt_t ctrl_out,
  input wire logic hold_en,
  input wire field_t hold_field,
  output logic meas_valid,
  output field_t meas_field
);
  // ==========================================
  // Supply, magnet and probe path
  int cnt;
  field_t fld;
  // Crude magnet of 10 uV drive per uT, unless the bench pins the field
  assign fld = hold_en ? hold_field : field_t'(ctrl_out / 10);
  // Period shortened like the tick so a run stays short
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 0;
      meas_valid <= 1'b0;
    end else begin
      cnt <= (cnt == MEAS_CYC - 1) ? 0 : cnt + 1;
      meas_valid <= (cnt == MEAS_CYC - 1);
    end
  end
  // Reading scrambled between strobes so a stale value is never reused
  assign meas_field = meas_valid ? fld : ~fld;
endmodule
`default_nettype wire

// *** verif/magnet_field_pi_controller_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fc_params.svh"
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (g), (e)); \
  end \
end
module magnet_field_pi_controller_tb
  import fc_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rv;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic option_present = 1'b1, dc_mode = 1'b1, single_axis = 1'b1, hold_en = 1'b1;
  field_t hold_field = 32'h0;
  wire logic awready, wready, bvalid, arready, rvalid, meas_valid, limit_warn, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire field_t meas_field;
  wire volt_t ctrl_out;
  logic [1:0] lr;
  int err_total = 0, samples_checked = 0, cyc = 0, dlt, maxd = 0;
  volt_t prev = 25'h0, v1;

  always #2.5 aclk = ~aclk;

  fc_field_ctrl #(.TICK_CYC(20)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .option_present(option_present), .dc_mode(dc_mode),
    .single_axis(single_axis), .meas_valid(meas_valid), .meas_field(meas_field),
    .ctrl_out(ctrl_out), .limit_warn(limit_warn), .irq(irq));

  fc_magnet_model #(.MEAS_CYC(200)) probe (.aclk(aclk), .aresetn(aresetn), .ctrl_out(ctrl_out),
    .hold_en(hold_en), .hold_field(hold_field), .meas_valid(meas_valid), .meas_field(meas_field));

  // ==========================================
  // Largest output step seen, and hang guard
  always @(posedge aclk) begin
    dlt = int'(ctrl_out) - int'(prev);
    if (dlt < 0) dlt = -dlt;
    if (dlt > maxd) maxd = dlt;
    prev = ctrl_out;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================
  // Bus master
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && awready) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (!tw && wready) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
    lr = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rv = rdata;
    lr = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rv, e)
  endtask

  // ==========================================
  // Scenarios
  task automatic t_regs();
    rchk(`FC_OFS_VLIMIT, 32'h00989680);
    rchk(`FC_OFS_SLEW, 32'h00002710);
    rchk(`FC_OFS_PGAIN, 32'h00000500);
    rchk(`FC_OFS_ITIME, 32'h00002710);
    rchk(`FC_OFS_ISTAT, 32'h00000000);
    rd(8'h30);
    `CHK(lr, 2'b10)
    wr(8'h40, 32'h00000001);
    `CHK(lr, 2'b10)
    $display("test regs done");
  endtask

  task automatic t_gate();
    wr(`FC_OFS_SLEW, 32'h000186a0);
    wr(`FC_OFS_OPENV, 32'h000f4240);
    {option_present, dc_mode, single_axis} <= 3'b110;
    wr(`FC_OFS_CTRL, 32'h00000001);
    for (int i = 0; i < 3; i++) begin
      {option_present, dc_mode, single_axis} <= ~(3'b001 << i);
      wt(150);
      `CHK(ctrl_out, 25'h0000000)
    end
    rd(`FC_OFS_STATUS);
    `CHK(rv[0], 1'b0)
    $display("test gate done");
  endtask

  task automatic t_open();
    maxd = 0;
    {option_present, dc_mode, single_axis} <= 3'b111;
    wt(400);
    `CHK(ctrl_out, 25'h00f4240)
    `CHK(maxd <= 100000, 1'b1)
    $display("test open done");
  endtask

  task automatic t_limit();
    wr(`FC_OFS_VLIMIT, 32'h0007a120);
    wr(`FC_OFS_OPENV, 32'h001e8480);
    wt(400);
    `CHK(ctrl_out, 25'h007a120)
    `CHK(limit_warn, 1'b1)
    `CHK(irq, 1'b0)
    wr(`FC_OFS_IMASK, 32'h00000001);
    `CHK(irq, 1'b1)
    wr(`FC_OFS_OPENV, 32'hffe17b80);
    wt(400);
    `CHK(ctrl_out, 25'h1f85ee0)
    maxd = 0;
    wr(`FC_OFS_CTRL, 32'h00000000);
    wt(400);
    `CHK(ctrl_out, 25'h0000000)
    `CHK(maxd <= 100000, 1'b1)
    `CHK(limit_warn, 1'b0)
    wr(`FC_OFS_ISTAT, 32'h00000007);
    `CHK(irq, 1'b0)
    wr(`FC_OFS_IMASK, 32'h00000000);
    $display("test limit done");
  endtask

  task automatic t_prop();
    hold_field <= 32'h00000258;
    wr(`FC_OFS_VLIMIT, 32'h00989680);
    wr(`FC_OFS_SLEW, 32'h00989680);
    wr(`FC_OFS_PGAIN, 32'h00000100);
    wr(`FC_OFS_ITIME, 32'h00000000);
    wr(`FC_OFS_SETPT, 32'h000003e8);
    wr(`FC_OFS_CTRL, 32'h00000003);
    wt(500);
    `CHK(ctrl_out, 25'h0000190)
    hold_field <= 32'h000005dc;
    wr(`FC_OFS_PGAIN, 32'h00000200);
    wt(500);
    `CHK(ctrl_out, 25'h1fffc18)
    hold_field <= 32'h000003e8;
    wt(500);
    `CHK(ctrl_out, 25'h0000000)
    wr(`FC_OFS_SETPT, 32'h000007d0);
    wt(300);
    `CHK(ctrl_out, 25'h00007d0)
    wr(`FC_OFS_ISTAT, 32'h00000002);
    wr(`FC_OFS_RAMP, 32'h00000064);
    wr(`FC_OFS_SETPT, 32'h00000bb8);
    rd(`FC_OFS_STATUS);
    `CHK(rv[2], 1'b1)
    wt(500);
    `CHK(ctrl_out, 25'h0000fa0)
    rd(`FC_OFS_ISTAT);
    `CHK(rv[1], 1'b1)
    wr(`FC_OFS_RAMP, 32'h00000000);
    $display("test prop done");
  endtask

  task automatic t_integ();
    wr(`FC_OFS_PGAIN, 32'h00000100);
    wr(`FC_OFS_SETPT, 32'h000003e8);
    hold_field <= 32'h00000384;
    wr(`FC_OFS_ITIME, 32'h00000001);
    wr(`FC_OFS_CTRL, 32'h00000007);
    wt(700);
    hold_field <= 32'h000003e8;
    wt(450);
    v1 = ctrl_out;
    `CHK(v1 > 25'sh0, 1'b1)
    wt(450);
    `CHK(ctrl_out, v1)
    wr(`FC_OFS_ITIME, 32'h00000002);
    wt(450);
    `CHK(ctrl_out, volt_t'(v1 / 2))
    wr(`FC_OFS_VLIMIT, 32'h00000032);
    wt(250);
    hold_field <= 32'h00000384;
    wt(450);
    `CHK(ctrl_out, 25'h0000032)
    `CHK(limit_warn, 1'b1)
    hold_field <= 32'h000003e8;
    wr(`FC_OFS_VLIMIT, 32'h00989680);
    wt(450);
    `CHK(ctrl_out, volt_t'(v1 / 2))
    wr(`FC_OFS_CTRL, 32'h00000003);
    wt(450);
    `CHK(ctrl_out, 25'h0000000)
    $display("test integ done");
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    wt(2);
    t_regs();
    t_gate();
    t_open();
    t_limit();
    t_prop();
    t_integ();
    end_sim();
  end
endmodule
`default_nettype wire
